// [hdl/mies_core.sv]
// Execution core for a subset of the 8-bit instruction set.
`timescale 1ns/1ps
`include "mies_map.svh"

// Summary of operation
// (RL1) Decrement-into-working: memory minus one, zero flag.
// (RL2) Sleep halts execution and drops the clock request.
// (RL3) Sleep clears watchdog counter and prescaler.
// (RL4) Sleep sets sleep flag, clears expired flag.
// (RL5) Increment memory in place, update zero flag.
// (RL6) Increment-into-working: memory plus one, zero flag.
// (RL7) Branch loads address, two cycles, no flags.
// (RL8) Copy memory to working, no flags.
// (RL9) Load literal into working, no flags.
// (RL10) Copy working to memory, no flags.
// (RL11) Idle op changes nothing but program counter.
// (RL12) Other ops take one cycle, counter plus one.
module mies_core (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [`MIES_INSTR_W-1:0] instr_i,
	input wire logic wake_i,
	input wire logic watchdog_expire_i,
	output logic [`MIES_PC_W-1:0] pc_o,
	output logic [`MIES_DATA_W-1:0] working_register_o,
	output logic zero_flag_o,
	output logic sleep_entered_flag_o,
	output logic watchdog_expired_flag_o,
	output logic watchdog_clear_o,
	output logic clock_run_o,
	output logic instr_done_o
);
	mies_pkg::mies_state_e state;
	mies_pkg::mies_state_e next_state;
	logic [`MIES_PC_W-1:0] next_pc;
	logic [`MIES_DATA_W-1:0] next_working;
	logic next_zero;
	logic next_sleep_flag;
	logic next_expired_flag;
	logic watchdog_clear;
	logic next_watchdog_clear;

	// Instruction fields: opcode on top, then address or literal or branch target.
	wire logic [`MIES_OP_W-1:0] opcode = instr_i[15:11];
	wire logic [`MIES_ADDR_W-1:0] mem_addr = instr_i[`MIES_ADDR_W-1:0];
	wire logic [`MIES_DATA_W-1:0] literal = instr_i[`MIES_DATA_W-1:0];
	wire logic [`MIES_PC_W-1:0] target = instr_i[`MIES_PC_W-1:0];
	wire logic [`MIES_DATA_W-1:0] mem_rd;
	wire logic running = (state == mies_pkg::MIES_RUN);

	// Shared arithmetic for the three increment and decrement forms.
	function automatic logic [`MIES_DATA_W-1:0] step_byte(input logic [`MIES_DATA_W-1:0] v,
			input logic down);
		step_byte = down ? v - 8'h01 : v + 8'h01;
	endfunction

	// Decode the memory write; only increment-memory and copy-to-memory write.
	wire logic is_incm = running && (opcode == `MIES_OP_INCM);
	wire logic is_movma = running && (opcode == `MIES_OP_MOVMA);
	wire logic mem_we = is_incm || is_movma;
	wire logic [`MIES_DATA_W-1:0] mem_wd = is_incm ? step_byte(mem_rd, 1'b0)
		: working_register_o;

	mies_data_mem u_mem (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.addr_i(mem_addr),
		.wr_en_i(mem_we),
		.wr_data_i(mem_wd),
		.rd_data_o(mem_rd)
	);

	// Next-state decode. Opcodes outside the subset behave as idle.
	always_comb begin
		next_state = state;
		next_pc = pc_o;
		next_working = working_register_o;
		next_zero = zero_flag_o;
		next_sleep_flag = sleep_entered_flag_o;
		next_expired_flag = watchdog_expired_flag_o;
		next_watchdog_clear = 1'b0;
		if (watchdog_expire_i) begin
			next_expired_flag = 1'b1;
		end
		case (state)
			mies_pkg::MIES_RUN: begin
				next_pc = pc_o + `MIES_PC_STEP; // RL12
				case (opcode)
					`MIES_OP_DEC_W: begin
						next_working = step_byte(mem_rd, 1'b1); // RL1
						next_zero = (step_byte(mem_rd, 1'b1) == 8'h00); // RL1
					end
					`MIES_OP_SLEEP: begin
						next_state = mies_pkg::MIES_HALTED; // RL2
						next_watchdog_clear = 1'b1; // RL3
						next_sleep_flag = 1'b1; // RL4
						next_expired_flag = 1'b0; // RL4
					end
					`MIES_OP_INCM: begin
						next_zero = (mem_wd == 8'h00); // RL5
					end
					`MIES_OP_INC_W: begin
						next_working = step_byte(mem_rd, 1'b0); // RL6
						next_zero = (step_byte(mem_rd, 1'b0) == 8'h00); // RL6
					end
					`MIES_OP_BRANCH: begin
						next_pc = target; // RL7
						next_state = mies_pkg::MIES_DUMMY; // RL7
					end
					`MIES_OP_MOVAM: begin
						next_working = mem_rd; // RL8
					end
					`MIES_OP_MOVAX: begin
						next_working = literal; // RL9
					end
					`MIES_OP_MOVMA: begin
						next_working = working_register_o; // RL10
					end
					default: begin
						next_working = working_register_o; // RL11
					end
				endcase
			end
			mies_pkg::MIES_DUMMY: begin
				next_state = mies_pkg::MIES_RUN; // RL7
			end
			mies_pkg::MIES_HALTED: begin
				// Wake-up leaves both sleep-related flags for software to inspect.
				if (wake_i) begin
					next_state = mies_pkg::MIES_RUN;
				end
			end
			default: begin
				next_state = mies_pkg::MIES_RUN;
			end
		endcase
	end

	// State registers; while halted the watchdog clear drops and the expired flag can still set; the rest hold.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= mies_pkg::MIES_RUN;
			pc_o <= `MIES_PC_RESET;
			working_register_o <= `MIES_W_RESET;
			zero_flag_o <= 1'b0;
			sleep_entered_flag_o <= 1'b0;
			watchdog_expired_flag_o <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			state <= next_state;
			pc_o <= next_pc;
			working_register_o <= next_working;
			zero_flag_o <= next_zero;
			sleep_entered_flag_o <= next_sleep_flag;
			watchdog_expired_flag_o <= next_expired_flag;
			watchdog_clear <= next_watchdog_clear;
		end
	end

	// The clock request drops while halted; the clock unit outside gates the clock.
	assign clock_run_o = (state != mies_pkg::MIES_HALTED); // RL2
	assign watchdog_clear_o = watchdog_clear; // RL3
	assign instr_done_o = running;
endmodule // mies_core

// [hdl/mies_map.svh]
// Constants for the instruction execution subset: widths, opcodes, reset values and counts.
`ifndef MIES_MAP_SVH
`define MIES_MAP_SVH
`define MIES_DATA_W 8
`define MIES_ADDR_W 7
`define MIES_PC_W 11
`define MIES_OP_W 5
`define MIES_INSTR_W 16
`define MIES_MEM_DEPTH 128
`define MIES_OP_IDLE 5'h00
`define MIES_OP_DEC_W 5'h01
`define MIES_OP_SLEEP 5'h02
`define MIES_OP_INCM 5'h03
`define MIES_OP_INC_W 5'h04
`define MIES_OP_BRANCH 5'h05
`define MIES_OP_MOVAM 5'h06
`define MIES_OP_MOVAX 5'h07
`define MIES_OP_MOVMA 5'h08
`define MIES_PC_RESET 11'h000
`define MIES_W_RESET 8'h00
`define MIES_MEM_RESET 8'h00
`define MIES_BRANCH_CYCLES 2
`define MIES_PC_STEP 11'h001
`endif

// [hdl/mies_pkg.sv]
// Types for the instruction execution subset.
package mies_pkg;
	typedef enum logic [1:0] {
		MIES_RUN = 2'b00,
		MIES_DUMMY = 2'b01,
		MIES_HALTED = 2'b10
	} mies_state_e;
	typedef logic [7:0] mies_byte_t;
endpackage

// [hdl/mies_data_mem.sv]
// Data memory held in flip-flops with one combinational read port and one write port.
`timescale 1ns/1ps
`include "mies_map.svh"
module mies_data_mem (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [`MIES_ADDR_W-1:0] addr_i,
	input wire logic wr_en_i,
	input wire logic [`MIES_DATA_W-1:0] wr_data_i,
	output logic [`MIES_DATA_W-1:0] rd_data_o
);
	logic [`MIES_DATA_W-1:0] mem [`MIES_MEM_DEPTH];

	// The read is combinational so an instruction can read and modify in one cycle.
	assign rd_data_o = mem[addr_i];

	// Contents only change on reset or an explicit write, which keeps them through sleep.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `MIES_MEM_DEPTH; i++) begin
				mem[i] <= `MIES_MEM_RESET;
			end
		end else if (wr_en_i) begin
			mem[addr_i] <= wr_data_i;
		end
	end
endmodule // mies_data_mem

// [verification/mies_core_asserts.sv]
// Checker for the instruction execution subset core.
`timescale 1ns/1ps
`include "mies_map.svh"
module mies_core_asserts (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [`MIES_INSTR_W-1:0] instr_i,
	input wire logic [`MIES_PC_W-1:0] pc_o,
	input wire logic [`MIES_DATA_W-1:0] working_register_o,
	input wire logic zero_flag_o,
	input wire logic sleep_entered_flag_o,
	input wire logic watchdog_expired_flag_o,
	input wire logic watchdog_clear_o,
	input wire logic clock_run_o,
	input wire logic instr_done_o
);
	// Opcode decode of the instruction taken at this edge.
	wire logic [4:0] op = instr_i[15:11];
	wire logic t_br = instr_done_o && op == `MIES_OP_BRANCH;
	wire logic t_slp = instr_done_o && op == `MIES_OP_SLEEP;
	wire logic t_acc = instr_done_o && (op == `MIES_OP_DEC_W || op == `MIES_OP_INC_W);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_branch;
		t_br ##1 !instr_done_o;
	endsequence
	property p_br_tgt;
		t_br |=> pc_o == $past(instr_i[10:0]) && $stable(zero_flag_o);
	endproperty
	a_br_tgt: assert property (p_br_tgt) else $error("bad branch target");
	property p_br_two;
		s_branch |=> instr_done_o;
	endproperty
	a_br_two: assert property (p_br_two) else $error("bad branch length");
	property p_step;
		instr_done_o && op != `MIES_OP_BRANCH |=> pc_o == $past(pc_o) + `MIES_PC_STEP;
	endproperty
	a_step: assert property (p_step) else $error("bad pc step");
	property p_sleep;
		t_slp |=> !clock_run_o && sleep_entered_flag_o && !watchdog_expired_flag_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("bad sleep flags");
	property p_clear;
		t_slp |=> watchdog_clear_o ##1 !watchdog_clear_o;
	endproperty
	a_clear: assert property (p_clear) else $error("bad watchdog clear");
	property p_zero;
		t_acc |=> zero_flag_o == (working_register_o == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("bad zero flag");
	property p_idle;
		instr_done_o && op == `MIES_OP_IDLE |=> $stable(working_register_o) && $stable(zero_flag_o);
	endproperty
	a_idle: assert property (p_idle) else $error("idle changed state");
	property p_halt;
		!clock_run_o |-> !instr_done_o ##1 $stable(pc_o);
	endproperty
	a_halt: assert property (p_halt) else $error("ran while halted");
endmodule // mies_core_asserts

// [verification/tb_mies_core.sv]
// Self-checking bench for the instruction execution subset core.
`timescale 1ns/1ps
`include "mies_map.svh"
module tb_mies_core;
	logic clk_i = 0;
	logic reset_n_i = 0;
	logic [15:0] instr_i = 16'h0000;
	logic wake_i = 0;
	logic watchdog_expire_i = 0;
	logic [10:0] pc_o;
	logic [7:0] working_register_o;
	logic zero_flag_o, sleep_entered_flag_o, watchdog_expired_flag_o;
	logic watchdog_clear_o, clock_run_o, instr_done_o;
	int bad_count = 0;
	int compares = 0;
	// Rows hold instruction, then expected working register and zero flag.
	logic [24:0] rows [13] = '{
		{`MIES_OP_MOVAX, 11'h07f, 9'h0fe}, {`MIES_OP_MOVMA, 11'h005, 9'h0fe},
		{`MIES_OP_INCM, 11'h005, 9'h0fe}, {`MIES_OP_MOVAM, 11'h005, 9'h100},
		{`MIES_OP_DEC_W, 11'h005, 9'h0fe}, {`MIES_OP_INC_W, 11'h005, 9'h102},
		{`MIES_OP_MOVAX, 11'h0ff, 9'h1fe}, {`MIES_OP_MOVMA, 11'h009, 9'h1fe},
		{`MIES_OP_INC_W, 11'h009, 9'h001}, {`MIES_OP_DEC_W, 11'h009, 9'h1fc},
		{`MIES_OP_INCM, 11'h009, 9'h1fd}, {`MIES_OP_MOVAM, 11'h009, 9'h001},
		{`MIES_OP_IDLE, 11'h000, 9'h001}};
	mies_core dut (.clk_i, .reset_n_i, .instr_i, .wake_i, .watchdog_expire_i, .pc_o,
		.working_register_o, .zero_flag_o, .sleep_entered_flag_o, .watchdog_expired_flag_o,
		.watchdog_clear_o, .clock_run_o, .instr_done_o);
	// Free-running clock.
	always #25 clk_i = ~clk_i;
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Inputs move 1 ns after the edge so the sampling edge never races them.
	task automatic step(input logic [15:0] i);
		instr_i = i;
		@(posedge clk_i);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence: table, branch, sleep and wake, then reset in mid-run.
	initial begin
		repeat (8) @(posedge clk_i);
		#1;
		chk({pc_o, working_register_o, zero_flag_o, clock_run_o}, 24'h000001);
		reset_n_i = 1;
		for (int r = 0; r < 13; r++) begin
			step(rows[r][24:9]);
			chk({working_register_o, zero_flag_o}, rows[r][8:0]);
			chk(pc_o, 24'(r + 1));
		end
		step({`MIES_OP_BRANCH, 11'h123});
		chk({instr_done_o, pc_o}, 24'h000123);
		step({`MIES_OP_MOVAX, 11'h055});
		chk({instr_done_o, pc_o, working_register_o, zero_flag_o}, 24'h124601);
		watchdog_expire_i = 1;
		step(16'h0000);
		watchdog_expire_i = 0;
		chk({pc_o, watchdog_expired_flag_o}, {11'h124, 1'b1});
		step({`MIES_OP_SLEEP, 11'h000});
		chk({clock_run_o, sleep_entered_flag_o}, 24'h1);
		chk({watchdog_expired_flag_o, watchdog_clear_o}, 24'h1);
		step({`MIES_OP_MOVAX, 11'h0aa});
		chk({pc_o, working_register_o, watchdog_clear_o}, {11'h125, 8'h00, 1'b0});
		wake_i = 1;
		for (int n = 0; n < 8 && clock_run_o !== 1'b1; n++) step(16'h0000);
		wake_i = 0;
		chk(clock_run_o, 24'h1);
		reset_n_i = 0;
		#1;
		chk({pc_o, sleep_entered_flag_o}, 24'h0);
		// Hold the second reset across an edge, then run one instruction from zero.
		@(posedge clk_i);
		#1;
		reset_n_i = 1;
		step({`MIES_OP_MOVAX, 11'h03c});
		chk({pc_o, working_register_o, sleep_entered_flag_o, clock_run_o}, {11'h001, 8'h3c, 2'b01});
		tally_and_finish();
	end
endmodule // tb_mies_core
bind mies_core mies_core_asserts u_chk (.clk_i, .reset_n_i, .instr_i, .pc_o,
	.working_register_o, .zero_flag_o, .sleep_entered_flag_o, .watchdog_expired_flag_o,
	.watchdog_clear_o, .clock_run_o, .instr_done_o);
